// File: design/smirq_pkg.sv
// package: offsets, field positions and reset values of the interrupt block
package smirq_pkg;
    localparam int SMIRQ_AW = 8;
    localparam int SMIRQ_NSRC = 6;
    localparam logic [7:0] SMIRQ_OFF_MASK = 8'h2c;
    localparam logic [7:0] SMIRQ_OFF_MSTAT = 8'h30;
    localparam logic [7:0] SMIRQ_OFF_RSTAT = 8'h34;
    localparam logic [7:0] SMIRQ_OFF_TXOCLR = 8'h38;
    localparam logic [7:0] SMIRQ_OFF_RXOCLR = 8'h3c;
    localparam logic [7:0] SMIRQ_OFF_EVSTAT = 8'h60;
    localparam logic [7:0] SMIRQ_OFF_EVMASK = 8'h64;
    localparam int SMIRQ_BIT_CONT = 5;
    localparam int SMIRQ_BIT_RXF = 4;
    localparam int SMIRQ_BIT_RXO = 3;
    localparam int SMIRQ_BIT_RXU = 2;
    localparam int SMIRQ_BIT_TXO = 1;
    localparam int SMIRQ_BIT_TXE = 0;
    localparam logic [5:0] SMIRQ_MASK_RST = 6'h3f;
    localparam logic [5:0] SMIRQ_STAT_RST = 6'h00;
    localparam logic [5:0] SMIRQ_EVMASK_RST = 6'h00;
endpackage : smirq_pkg

// File: design/smirq_latch.sv
// sticky overflow latch: set by a pulse, cleared by a read, set wins
`timescale 1ns/1ps
`default_nettype none
module smirq_latch
    import smirq_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_d;
    assign flag_d = set_i | (flag_o & ~clr_i);
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= flag_d;
        end
    end
endmodule : smirq_latch
`default_nettype wire

// File: design/smirq_edge.sv
// rising edge detector for a level source
`timescale 1ns/1ps
`default_nettype none
module smirq_edge (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic lvl_i,
    output logic rise_o
);
    logic prev_q;
    assign rise_o = lvl_i & ~prev_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= lvl_i;
        end
    end
endmodule : smirq_edge
`default_nettype wire

// File: design/smirq_top.sv
// interrupt status and clear logic of the spi master
// Summary of operation
// - masked status at 0x30 is read-only, six sources after masking.
// - a masked bit is one only when its source is active and enabled.
// - raw status at 0x34 is read-only, six sources before masking.
// - a raw bit is one whenever its source is active, whatever the mask.
// - bit map: contention 5, rxf 4, rxo 3, rxu 2, txo 1, txe 0.
// - reading 0x38 clears the latched tx overflow interrupt.
// - bit 0 of that read returns the tx overflow state before the clear.
// - reading 0x3c clears the latched rx overflow interrupt.
// - bit 0 of that read returns the rx overflow state before the clear.
// - writes to the two clear registers change nothing.
// - mask at 0x2c: one enables a source, zero masks it, same layout.
`timescale 1ns/1ps
`default_nettype none
module smirq_top
    import smirq_pkg::*;
#(
    parameter int NSRC = SMIRQ_NSRC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [SMIRQ_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic contention_irq_i,
    input wire logic rx_full_irq_i,
    input wire logic rx_overflow_set_i,
    input wire logic rx_underflow_irq_i,
    input wire logic tx_overflow_set_i,
    input wire logic tx_empty_irq_i,
    output logic spi_irq_o,
    output logic evt_irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic hit(input logic [SMIRQ_AW-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    wire rd_mask = rd_i & hit(addr_i, SMIRQ_OFF_MASK);
    wire rd_mstat = rd_i & hit(addr_i, SMIRQ_OFF_MSTAT);
    wire rd_rstat = rd_i & hit(addr_i, SMIRQ_OFF_RSTAT);
    wire rd_txoclr = rd_i & hit(addr_i, SMIRQ_OFF_TXOCLR);
    wire rd_rxoclr = rd_i & hit(addr_i, SMIRQ_OFF_RXOCLR);
    wire rd_evstat = rd_i & hit(addr_i, SMIRQ_OFF_EVSTAT);
    wire rd_evmask = rd_i & hit(addr_i, SMIRQ_OFF_EVMASK);
    wire wr_mask = wr_i & hit(addr_i, SMIRQ_OFF_MASK);
    wire wr_evstat = wr_i & hit(addr_i, SMIRQ_OFF_EVSTAT);
    wire wr_evmask = wr_i & hit(addr_i, SMIRQ_OFF_EVMASK);

    ////////////////////////////////////////////////////////////////////////
    // overflow latches, cleared by read only
    logic tx_overflow_irq;
    logic rx_overflow_irq;

    smirq_latch u_txo (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(tx_overflow_set_i),
        .clr_i(rd_txoclr),
        .flag_o(tx_overflow_irq)
    );

    smirq_latch u_rxo (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(rx_overflow_set_i),
        .clr_i(rd_rxoclr),
        .flag_o(rx_overflow_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // raw and masked status
    logic [NSRC-1:0] mask_q;
    logic [NSRC-1:0] mask_d;
    logic [NSRC-1:0] raw_stat;
    logic [NSRC-1:0] msk_stat;

    always_comb begin
        raw_stat = '0;
        raw_stat[SMIRQ_BIT_CONT] = contention_irq_i;
        raw_stat[SMIRQ_BIT_RXF] = rx_full_irq_i;
        raw_stat[SMIRQ_BIT_RXO] = rx_overflow_irq;
        raw_stat[SMIRQ_BIT_RXU] = rx_underflow_irq_i;
        raw_stat[SMIRQ_BIT_TXO] = tx_overflow_irq;
        raw_stat[SMIRQ_BIT_TXE] = tx_empty_irq_i;
    end

    assign msk_stat = raw_stat & mask_q;
    assign mask_d = wr_mask ? wdata_i[NSRC-1:0] : mask_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= SMIRQ_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky event status on source rising edges, write one to clear
    logic [NSRC-1:0] ev_rise;
    logic [NSRC-1:0] evstat_q;
    logic [NSRC-1:0] evstat_d;
    logic [NSRC-1:0] evmask_q;
    logic [NSRC-1:0] evmask_d;

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_edge
            smirq_edge u_edge (
                .clk_sys_i(clk_sys_i),
                .rst_b_i(rst_b_i),
                .lvl_i(raw_stat[gi]),
                .rise_o(ev_rise[gi])
            );
        end
    endgenerate

    assign evstat_d = ev_rise |
        (evstat_q & ~({NSRC{wr_evstat}} & wdata_i[NSRC-1:0]));
    assign evmask_d = wr_evmask ? wdata_i[NSRC-1:0] : evmask_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            evstat_q <= SMIRQ_STAT_RST;
            evmask_q <= SMIRQ_EVMASK_RST;
        end else begin
            evstat_q <= evstat_d;
            evmask_q <= evmask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and interrupt outputs
    logic [31:0] rdata_d;
    logic spi_irq_d;
    logic evt_irq_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_mask) begin
            rdata_d[NSRC-1:0] = mask_q;
        end else if (rd_mstat) begin
            rdata_d[NSRC-1:0] = msk_stat;
        end else if (rd_rstat) begin
            rdata_d[NSRC-1:0] = raw_stat;
        end else if (rd_txoclr) begin
            rdata_d[0] = tx_overflow_irq;
        end else if (rd_rxoclr) begin
            rdata_d[0] = rx_overflow_irq;
        end else if (rd_evstat) begin
            rdata_d[NSRC-1:0] = evstat_q;
        end else if (rd_evmask) begin
            rdata_d[NSRC-1:0] = evmask_q;
        end
    end

    assign spi_irq_d = |msk_stat;
    assign evt_irq_d = |(evstat_q & evmask_q);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
            spi_irq_o <= 1'b0;
            evt_irq_o <= 1'b0;
        end else begin
            rdata_o <= rdata_d;
            spi_irq_o <= spi_irq_d;
            evt_irq_o <= evt_irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_mstat_read: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_mstat |=> rdata_o == {26'h0, $past(raw_stat & mask_q)})
        else $error("masked status read wrong");

    a_mstat_upper: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_mstat |=> rdata_o[31:6] == 26'h0)
        else $error("masked status upper bits nonzero");

    a_mask_gate: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (msk_stat == 6'h00) |=> !spi_irq_o)
        else $error("irq high with nothing unmasked");

    a_irq_set: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (msk_stat != 6'h00) |=> spi_irq_o)
        else $error("irq low with an unmasked source");

    a_mstat_bit: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_mstat && !mask_q[SMIRQ_BIT_TXE] |=> !rdata_o[SMIRQ_BIT_TXE])
        else $error("masked source shows in masked status");

    a_rstat_val: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat |=> rdata_o == {26'h0, $past(raw_stat)})
        else $error("raw status read wrong");

    a_rstat_read: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat && tx_empty_irq_i |=> rdata_o[0])
        else $error("raw status lost tx empty");

    a_rstat_upper: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat |=> rdata_o[31:6] == 26'h0)
        else $error("raw status upper bits nonzero");

    a_cont_pos: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat && contention_irq_i |=> rdata_o[5])
        else $error("contention not at bit 5");

    a_rxf_pos: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat && rx_full_irq_i |=> rdata_o[SMIRQ_BIT_RXF])
        else $error("rx full not at its bit");

    a_rxo_pos: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat && rx_overflow_irq |=> rdata_o[SMIRQ_BIT_RXO])
        else $error("rx overflow not at its bit");

    a_rxu_pos: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat && rx_underflow_irq_i |=> rdata_o[SMIRQ_BIT_RXU])
        else $error("rx underflow not at its bit");

    a_txo_pos: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rstat && tx_overflow_irq |=> rdata_o[SMIRQ_BIT_TXO])
        else $error("tx overflow not at its bit");

    a_txo_clear: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_txoclr && !tx_overflow_set_i |=> !tx_overflow_irq)
        else $error("tx overflow not cleared by read");

    a_set_wins: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        tx_overflow_set_i |=> tx_overflow_irq)
        else $error("overflow event lost");

    a_txo_value: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_txoclr |=> rdata_o == {31'h0, $past(tx_overflow_irq)})
        else $error("tx clear read value wrong");

    a_txo_upper: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_txoclr |=> rdata_o[31:1] == 31'h0)
        else $error("tx clear upper bits nonzero");

    a_rxo_clear: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rxoclr && !rx_overflow_set_i |=> !rx_overflow_irq)
        else $error("rx overflow not cleared by read");

    a_rxo_sticky: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rx_overflow_set_i |=> rx_overflow_irq)
        else $error("rx overflow event lost");

    a_rxo_value: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rxoclr |=> rdata_o == {31'h0, $past(rx_overflow_irq)})
        else $error("rx clear read value wrong");

    a_rxo_upper: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_rxoclr |=> rdata_o[31:1] == 31'h0)
        else $error("rx clear upper bits nonzero");

    a_clr_wr_none: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_i && (hit(addr_i, SMIRQ_OFF_TXOCLR) ||
            hit(addr_i, SMIRQ_OFF_RXOCLR)) && tx_overflow_irq
            |=> tx_overflow_irq)
        else $error("write to clear register had effect");

    a_rxo_wr_none: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_i && hit(addr_i, SMIRQ_OFF_RXOCLR) && rx_overflow_irq
            |=> rx_overflow_irq)
        else $error("write to rx clear register had effect");

    a_clr_wr_mask: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_i && (hit(addr_i, SMIRQ_OFF_TXOCLR) ||
            hit(addr_i, SMIRQ_OFF_RXOCLR)) |=> mask_q == $past(mask_q))
        else $error("write to clear register changed mask");

    a_mask_write: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_mask |=> mask_q == $past(wdata_i[5:0]))
        else $error("mask write not stored");

    a_mask_hold: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !wr_mask |=> mask_q == $past(mask_q))
        else $error("mask changed without a write");

    a_evt_gate: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ((evstat_q & evmask_q) == 6'h00) |=> !evt_irq_o)
        else $error("event irq high with nothing enabled");
endmodule : smirq_top
`default_nettype wire

// File: verification/smirq_src_model.sv
// source model: fifo core levels and overflow event pulses
`timescale 1ns/1ps
`default_nettype none
module smirq_src_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [5:0] want_i,
    output logic [5:0] src_o
);
    logic [5:0] prev_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= want_i;
        end
    end
    // overflow bits fire once per rising request, others are levels
    assign src_o = want_i & ~(prev_q & 6'h0a);
endmodule : smirq_src_model
`default_nettype wire

// File: verification/smirq_top_tb.sv
// self-checking bench of the spi master interrupt status block
`timescale 1ns/1ps
`default_nettype none
module smirq_top_tb;
    import smirq_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [SMIRQ_AW-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [5:0] want = '0;
    logic [5:0] src;
    logic [31:0] rdata_o;
    logic [31:0] got;
    logic spi_irq_o;
    logic evt_irq_o;
    int fails = 0;
    int n_compared = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    smirq_src_model src_mdl (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .want_i(want), .src_o(src));
    smirq_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .contention_irq_i(src[5]),
        .rx_full_irq_i(src[4]), .rx_overflow_set_i(src[3]),
        .rx_underflow_irq_i(src[2]), .tx_overflow_set_i(src[1]),
        .tx_empty_irq_i(src[0]), .spi_irq_o(spi_irq_o),
        .evt_irq_o(evt_irq_o));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        got = rdata_o;
    endtask : rd
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(SMIRQ_OFF_MASK);
        check(got, 32'h0000_003f);
        rd(SMIRQ_OFF_MSTAT);
        check(got, 32'h0);
        rd(SMIRQ_OFF_RSTAT);
        check(got, 32'h0);
        rd(SMIRQ_OFF_TXOCLR);
        check(got, 32'h0);
        rd(SMIRQ_OFF_RXOCLR);
        check(got, 32'h0);
        check({31'h0, spi_irq_o}, 32'h0);
    endtask : t_reset
    // each source alone, raw and masked, overflow cleared by read
    task automatic t_each();
        for (int i = 0; i < 6; i++) begin
            want <= 6'h01 << i;
            rd(SMIRQ_OFF_RSTAT);
            check(got, 32'h1 << i);
            rd(SMIRQ_OFF_MSTAT);
            check(got, 32'h1 << i);
            check({31'h0, spi_irq_o}, 32'h1);
            want <= '0;
            if (i == SMIRQ_BIT_TXO) begin
                rd(SMIRQ_OFF_TXOCLR);
                check(got, 32'h1);
            end
            if (i == SMIRQ_BIT_RXO) begin
                rd(SMIRQ_OFF_RXOCLR);
                check(got, 32'h1);
            end
            rd(SMIRQ_OFF_RSTAT);
            check(got, 32'h0);
        end
    endtask : t_each
    // partial mask, ignored writes, double clear, unmapped read
    task automatic t_mask();
        wr(SMIRQ_OFF_MASK, 32'hffff_ff15);
        want <= 6'h3f;
        rd(SMIRQ_OFF_RSTAT);
        check(got, 32'h0000_003f);
        rd(SMIRQ_OFF_MSTAT);
        check(got, 32'h0000_0015);
        wr(SMIRQ_OFF_MASK, 32'h0);
        rd(SMIRQ_OFF_MSTAT);
        check(got, 32'h0);
        check({31'h0, spi_irq_o}, 32'h0);
        wr(SMIRQ_OFF_TXOCLR, 32'hffff_ffff);
        wr(SMIRQ_OFF_RXOCLR, 32'hffff_ffff);
        wr(SMIRQ_OFF_RSTAT, 32'h0);
        wr(SMIRQ_OFF_MSTAT, 32'hffff_ffff);
        rd(SMIRQ_OFF_RSTAT);
        check(got, 32'h0000_003f);
        rd(SMIRQ_OFF_MASK);
        check(got, 32'h0);
        rd(SMIRQ_OFF_TXOCLR);
        check(got, 32'h1);
        rd(SMIRQ_OFF_TXOCLR);
        check(got, 32'h0);
        rd(SMIRQ_OFF_RXOCLR);
        check(got, 32'h1);
        rd(SMIRQ_OFF_RXOCLR);
        check(got, 32'h0);
        rd(SMIRQ_OFF_RSTAT);
        check(got, 32'h0000_0035);
        rd(8'h50);
        check(got, 32'h0);
        want <= '0;
        wr(SMIRQ_OFF_MASK, 32'h0000_003f);
    endtask : t_mask
    // event status: sticky on a rising source, write one to clear
    task automatic t_event();
        wr(SMIRQ_OFF_EVSTAT, 32'h0000_003f);
        rd(SMIRQ_OFF_EVSTAT);
        check(got, 32'h0);
        wr(SMIRQ_OFF_EVMASK, 32'h0000_0004);
        rd(SMIRQ_OFF_EVMASK);
        check(got, 32'h0000_0004);
        check({31'h0, evt_irq_o}, 32'h0);
        want <= 6'h05;
        rd(SMIRQ_OFF_EVSTAT);
        check(got, 32'h0000_0005);
        check({31'h0, evt_irq_o}, 32'h1);
        want <= '0;
        wr(SMIRQ_OFF_EVSTAT, 32'h0000_0004);
        rd(SMIRQ_OFF_EVSTAT);
        check(got, 32'h0000_0001);
        check({31'h0, evt_irq_o}, 32'h0);
        wr(SMIRQ_OFF_EVSTAT, 32'h0000_0001);
        wr(SMIRQ_OFF_EVMASK, 32'h0);
    endtask : t_event
    // latched overflows and a cleared mask, then a reset in mid-run
    task automatic t_rst_mid();
        want <= 6'h0a;
        rd(SMIRQ_OFF_RSTAT);
        check(got, 32'h0000_000a);
        want <= '0;
        wr(SMIRQ_OFF_MASK, 32'h0);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(SMIRQ_OFF_RSTAT);
        check(got, 32'h0);
        rd(SMIRQ_OFF_MASK);
        check(got, 32'h0000_003f);
        rd(SMIRQ_OFF_TXOCLR);
        check(got, 32'h0);
        rd(SMIRQ_OFF_RXOCLR);
        check(got, 32'h0);
        check({31'h0, spi_irq_o}, 32'h0);
    endtask : t_rst_mid
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_each();
        t_mask();
        t_event();
        t_rst_mid();
        end_sim();
    end
endmodule : smirq_top_tb
`default_nettype wire
